//--- hw/dew_core_host.sv
// Core end: AXI4-Lite command registers driving external data moves
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
module dew_core_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  dew_link_if.core link
);
  import dew_pkg::*;

  dew_host_state_t h_q;
  dew_host_state_t h_d;
  logic [31:0] status;
  logic [3:0] req_page;

  assign status = {29'h0, h_q.expanded_ram, h_q.err, h_q.pending};
  assign req_page = h_q.addr[DEW_ROW_MSB:DEW_ROW_LSB];

  always_comb
  begin
    h_d = h_q;
    h_d.x_wr = 1'b0;
    h_d.x_rd = 1'b0;
    h_d.ctl_wr = 1'b0;
    if (awvalid && awready)
    begin
      h_d.aw_got = 1'b1;
      h_d.awaddr = awaddr;
    end
    if (wvalid && wready)
    begin
      h_d.w_got = 1'b1;
      h_d.wdata = wdata;
      h_d.wstrb = wstrb;
    end
    if (h_q.bvalid && bready)
    begin
      h_d.bvalid = 1'b0;
    end
    if (h_q.rvalid && rready)
    begin
      h_d.rvalid = 1'b0;
    end
    case (h_q.st)
      DEW_H_STROBE:
      begin
        h_d.st = DEW_H_IDLE;
        h_d.pending = 1'b0;
        if (h_q.op == DEW_OP_CTL_WRITE)
        begin
          h_d.shadow_sel = h_q.data[DEW_CTL_SEL_BIT];
          if (h_q.data[DEW_CTL_KEY_MSB:DEW_CTL_KEY_LSB] == DEW_KEY_SECOND)
          begin
            h_d.sess_open = 1'b0;
          end
        end
        else if (h_q.op == DEW_OP_STORE)
        begin
          h_d.sess_open = 1'b1;
          h_d.sess_page = req_page;
        end
        else if (h_q.op == DEW_OP_CTL_READ)
        begin
          h_d.result = link.ctl_rdata;
        end
        else if (link.x_expanded_ram_sel)
        begin
          h_d.expanded_ram = 1'b1;
        end
        else
        begin
          h_d.pending = 1'b1;
          h_d.st = DEW_H_LOAD;
        end
      end
      DEW_H_LOAD:
      begin
        if (link.x_rvalid)
        begin
          h_d.result = link.x_rdata;
          h_d.err = link.x_rerr;
          h_d.pending = 1'b0;
          h_d.st = DEW_H_IDLE;
        end
      end
      default:
      begin
        h_d.st = DEW_H_IDLE;
      end
    endcase
    // Write performed once both address and data are held
    if (h_q.aw_got && h_q.w_got)
    begin
      h_d.aw_got = 1'b0;
      h_d.w_got = 1'b0;
      h_d.bvalid = 1'b1;
      h_d.bresp = DEW_RESP_OKAY;
      if (h_q.awaddr == DEW_REG_ADDR)
      begin
        if (h_q.wstrb[0])
        begin
          h_d.addr[7:0] = h_q.wdata[7:0];
        end
        if (h_q.wstrb[1])
        begin
          h_d.addr[15:8] = h_q.wdata[15:8];
        end
      end
      else if (h_q.awaddr == DEW_REG_DATA)
      begin
        if (h_q.wstrb[0])
        begin
          h_d.data = h_q.wdata[7:0];
        end
      end
      else if (h_q.awaddr == DEW_REG_CMD)
      begin
        // A command while one is pending is ignored
        if (h_q.wstrb[0] && !h_q.pending)
        begin
          h_d.op = dew_op_t'(h_q.wdata[1:0]);
          h_d.err = 1'b0;
          h_d.expanded_ram = 1'b0;
          h_d.x_addr = h_q.addr;
          h_d.x_wdata = h_q.data;
          if (dew_op_t'(h_q.wdata[1:0]) == DEW_OP_STORE &&
              (!h_q.shadow_sel || (h_q.sess_open && req_page != h_q.sess_page)))
          begin
            h_d.err = 1'b1;
          end
          else
          begin
            h_d.pending = 1'b1;
            h_d.st = DEW_H_STROBE;
            h_d.ctl_wr = (h_q.wdata[1:0] == 2'h0);
            h_d.x_wr = (h_q.wdata[1:0] == 2'h1);
            h_d.x_rd = (h_q.wdata[1:0] == 2'h2);
          end
        end
      end
      else if (h_q.awaddr != DEW_REG_RESULT)
      begin
        h_d.bresp = DEW_RESP_SLVERR;
      end
    end
    if (arvalid && arready)
    begin
      h_d.rvalid = 1'b1;
      h_d.rresp = DEW_RESP_OKAY;
      if (araddr == DEW_REG_ADDR)
      begin
        h_d.rdata = {16'h0, h_q.addr};
      end
      else if (araddr == DEW_REG_DATA)
      begin
        h_d.rdata = {24'h0, h_q.data};
      end
      else if (araddr == DEW_REG_CMD)
      begin
        h_d.rdata = status;
      end
      else if (araddr == DEW_REG_RESULT)
      begin
        h_d.rdata = {24'h0, h_q.result};
      end
      else
      begin
        h_d.rdata = 32'h0;
        h_d.rresp = DEW_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      h_q <= DEW_HOST_RESET;
    end
    else
    begin
      h_q <= h_d;
    end
  end

  assign awready = !h_q.aw_got && !h_q.bvalid;
  assign wready = !h_q.w_got && !h_q.bvalid;
  assign bvalid = h_q.bvalid;
  assign bresp = h_q.bresp;
  assign arready = !h_q.rvalid;
  assign rvalid = h_q.rvalid;
  assign rdata = h_q.rdata;
  assign rresp = h_q.rresp;
  assign link.x_addr = h_q.x_addr;
  assign link.x_wdata = h_q.x_wdata;
  assign link.x_wr = h_q.x_wr;
  assign link.x_rd = h_q.x_rd;
  assign link.ctl_wr = h_q.ctl_wr;
  assign link.ctl_wdata = h_q.x_wdata;
endmodule : dew_core_host

//--- hw/dew_pkg.sv
// Constants and state types shared by the data EEPROM page writer ends
// How it works
// - EEPROM decodes 0000h-03FFh when space selected
// - Reads use ordinary external data moves
// - Load column latches, then program one row
// - One session writes 1 to 128 bytes
// - Ninth flag per latch; only flagged bytes programmed
// - Flags cleared after row programming completes
// - Upper 4 address bits row, lower 7 byte
// - Host keeps one page per session; the host ends it on any Ah nibble, even without a launch
// - First written page latched, later pages discarded; the device latches their bytes into the same columns of the first page
// - One latch byte per external store cycle
// - Host selects space, then stores bytes
// - Control writes 52h then A2h launch programming
// - Busy set on launch; reads unavailable meanwhile
// - Control bit 1 routes moves EEPROM or RAM
// - Busy cleared by hardware, never by software
// - Key decoded from control bits 7 to 4 only
package dew_pkg;
  localparam logic [15:0] DEW_EE_LAST = 16'h03ff;
  localparam int DEW_ARRAY_BYTES = 1024;
  localparam int DEW_PAGE_BYTES = 128;
  localparam int DEW_ROW_MSB = 10;
  localparam int DEW_ROW_LSB = 7;
  localparam int DEW_ARR_ROW_W = 3;
  localparam int DEW_CTL_BUSY_BIT = 0;
  localparam int DEW_CTL_SEL_BIT = 1;
  localparam int DEW_CTL_KEY_LSB = 4;
  localparam int DEW_CTL_KEY_MSB = 7;
  localparam logic [3:0] DEW_KEY_FIRST = 4'h5;
  localparam logic [3:0] DEW_KEY_SECOND = 4'ha;
  localparam logic [7:0] DEW_BUSY_READ_DATA = 8'hff;
  localparam int DEW_CLK_PERIOD_NS = 50;
  localparam int DEW_PROG_TIME_NS = 2000;
  localparam logic [11:0] DEW_PROG_CYCLES =
    12'((DEW_PROG_TIME_NS + DEW_CLK_PERIOD_NS - 1) / DEW_CLK_PERIOD_NS);
  // Host command registers seen over AXI4-Lite
  localparam logic [3:0] DEW_REG_ADDR = 4'h0;
  localparam logic [3:0] DEW_REG_DATA = 4'h4;
  localparam logic [3:0] DEW_REG_CMD = 4'h8;
  localparam logic [3:0] DEW_REG_RESULT = 4'hc;
  localparam logic [1:0] DEW_RESP_OKAY = 2'h0;
  localparam logic [1:0] DEW_RESP_SLVERR = 2'h2;
  localparam int DEW_ST_PENDING = 0;
  localparam int DEW_ST_ERR = 1;
  localparam int DEW_ST_EXPANDED_RAM = 2;

  typedef enum logic [1:0] {DEW_OP_CTL_WRITE, DEW_OP_STORE, DEW_OP_LOAD, DEW_OP_CTL_READ} dew_op_t;
  typedef enum logic [1:0] {DEW_IDLE, DEW_WALK, DEW_WAIT} dew_prog_t;
  typedef enum logic [1:0] {DEW_H_IDLE, DEW_H_STROBE, DEW_H_LOAD} dew_host_t;

  typedef struct packed {
    dew_prog_t st;
    logic sel;
    logic busy;
    logic [3:0] key;
    logic armed;
    logic [3:0] page;
    logic any;
    logic [7:0] count;
    logic [DEW_PAGE_BYTES-1:0] flags;
    logic [6:0] idx;
    logic [11:0] cnt;
    logic rvalid;
    logic rerr;
    logic [7:0] rdata;
  } dew_dev_state_t;

  typedef struct packed {
    logic aw_got;
    logic [3:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] addr;
    logic [7:0] data;
    dew_host_t st;
    dew_op_t op;
    logic pending;
    logic err;
    logic expanded_ram;
    logic [7:0] result;
    logic shadow_sel;
    logic sess_open;
    logic [3:0] sess_page;
    logic x_wr;
    logic x_rd;
    logic ctl_wr;
    logic [15:0] x_addr;
    logic [7:0] x_wdata;
  } dew_host_state_t;

  localparam dew_dev_state_t DEW_DEV_RESET = '0;
  localparam dew_host_state_t DEW_HOST_RESET = '0;
endpackage : dew_pkg

//--- hw/dew_link_if.sv
// Link between the processor core end and the data EEPROM end
interface dew_link_if;
  logic [15:0] x_addr;
  logic [7:0] x_wdata;
  logic x_wr;
  logic x_rd;
  logic [7:0] x_rdata;
  logic x_rvalid;
  logic x_rerr;
  logic x_expanded_ram_sel;
  logic ctl_wr;
  logic [7:0] ctl_wdata;
  logic [7:0] ctl_rdata;

  modport dev (
    input x_addr, x_wdata, x_wr, x_rd, ctl_wr, ctl_wdata,
    output x_rdata, x_rvalid, x_rerr, x_expanded_ram_sel, ctl_rdata
  );
  modport core (
    output x_addr, x_wdata, x_wr, x_rd, ctl_wr, ctl_wdata,
    input x_rdata, x_rvalid, x_rerr, x_expanded_ram_sel, ctl_rdata
  );
endinterface : dew_link_if

//--- hw/dew_device.sv
// Data EEPROM end: column latches, launch key, row programming
module dew_device (
  input wire logic aclk,
  input wire logic aresetn,
  dew_link_if.dev link,
  output logic program_in_progress_flag,
  output logic nvm_space_select,
  output logic [3:0] latched_page,
  output logic [7:0] latched_bytes
);
  import dew_pkg::*;

  dew_dev_state_t st_q;
  dew_dev_state_t st_d;
  logic [7:0] mem [0:DEW_ARRAY_BYTES-1];
  logic [7:0] lat [0:DEW_PAGE_BYTES-1];
  logic ee_hit;
  logic store_ok;
  logic launch;
  logic [3:0] wr_key;
  logic [6:0] col;

  assign ee_hit = st_q.sel && (link.x_addr <= DEW_EE_LAST);
  assign wr_key = link.ctl_wdata[DEW_CTL_KEY_MSB:DEW_CTL_KEY_LSB];
  assign col = link.x_addr[DEW_ROW_LSB-1:0];

  // One byte per store
  // Stores during programming are dropped so the row being written stays coherent
  assign store_ok = link.x_wr && ee_hit && !st_q.busy;

  assign launch = link.ctl_wr && st_q.armed && (wr_key == DEW_KEY_SECOND) && !st_q.busy;

  always_comb
  begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    st_d.rerr = 1'b0;
    if (link.ctl_wr)
    begin
      st_d.sel = link.ctl_wdata[DEW_CTL_SEL_BIT];
      st_d.key = wr_key;
      st_d.armed = (wr_key == DEW_KEY_FIRST) && !st_q.busy;
    end
    if (store_ok)
    begin
      st_d.flags[col] = 1'b1;
      // Count bytes up to a page
      if (!st_q.flags[col])
      begin
        st_d.count = st_q.count + 8'h01;
      end
      if (!st_q.any)
      begin
        st_d.page = link.x_addr[DEW_ROW_MSB:DEW_ROW_LSB];
      end
      st_d.any = 1'b1;
    end
    if (link.x_rd && ee_hit)
    begin
      st_d.rvalid = 1'b1;
      st_d.rerr = st_q.busy;
      if (st_q.busy)
      begin
        st_d.rdata = DEW_BUSY_READ_DATA;
      end
      else
      begin
        st_d.rdata = mem[link.x_addr[9:0]];
      end
    end
    case (st_q.st)
      DEW_IDLE:
      begin
        if (launch)
        begin
          st_d.busy = 1'b1;
          st_d.armed = 1'b0;
          st_d.idx = '0;
          st_d.st = DEW_WALK;
        end
      end
      DEW_WALK:
      begin
        st_d.idx = st_q.idx + 7'h01;
        if (st_q.idx == 7'(DEW_PAGE_BYTES - 1))
        begin
          st_d.cnt = DEW_PROG_CYCLES;
          st_d.st = DEW_WAIT;
        end
      end
      DEW_WAIT:
      begin
        st_d.cnt = st_q.cnt - 12'h001;
        if (st_q.cnt <= 12'h001)
        begin
          st_d.busy = 1'b0;
          st_d.flags = '0;
          st_d.any = 1'b0;
          st_d.count = '0;
          st_d.st = DEW_IDLE;
        end
      end
      default:
      begin
        st_d.st = DEW_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= DEW_DEV_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Latches and array hold no reset: contents survive a reset as real cells would
  always_ff @(posedge aclk)
  begin
    if (store_ok)
    begin
      lat[col] <= link.x_wdata;
    end
    if (st_q.st == DEW_WALK && st_q.flags[st_q.idx])
    begin
      mem[{st_q.page[DEW_ARR_ROW_W-1:0], st_q.idx}] <= lat[st_q.idx];
    end
  end

  assign link.x_rdata = st_q.rdata;
  assign link.x_rvalid = st_q.rvalid;
  assign link.x_rerr = st_q.rerr;
  assign link.x_expanded_ram_sel = (link.x_wr || link.x_rd) && !ee_hit;
  assign link.ctl_rdata = {st_q.key, 2'b00, st_q.sel, st_q.busy};
  assign program_in_progress_flag = st_q.busy;
  assign nvm_space_select = st_q.sel;
  assign latched_page = st_q.page;
  assign latched_bytes = st_q.count;
endmodule : dew_device

//--- dv/dew_assertions.sv
// Link checker between the core end and the data EEPROM end
module dew_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] x_addr,
  input wire logic x_wr,
  input wire logic x_rd,
  input wire logic [7:0] x_rdata,
  input wire logic x_rvalid,
  input wire logic x_rerr,
  input wire logic x_expanded_ram_sel,
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_wdata,
  input wire logic [7:0] ctl_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import dew_pkg::*;
  localparam int BUSY_CYCLES = DEW_PAGE_BYTES + int'(DEW_PROG_CYCLES);
  logic busy;
  logic launch;
  logic key5_q;
  logic [8:0] bcnt_q;
  assign busy = ctl_rdata[DEW_CTL_BUSY_BIT];
  assign launch = ctl_wr && ctl_wdata[7:4] == DEW_KEY_SECOND && key5_q && !busy;
  // Only a first nibble written while idle arms the key
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      key5_q <= 1'b0;
      bcnt_q <= 9'h000;
    end
    else
    begin
      if (ctl_wr)
        key5_q <= ctl_wdata[7:4] == DEW_KEY_FIRST && !busy;
      bcnt_q <= busy ? bcnt_q + 9'h001 : 9'h000;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_key_launch: assert property (launch |=> busy)
    else $error("launch key did not set busy");
  a_no_false_launch: assert property (!busy && !launch |=> !busy)
    else $error("busy rose without launch key");
  a_busy_length: assert property ($fell(busy) |-> bcnt_q == 9'(BUSY_CYCLES))
    else $error("busy length wrong");
  a_busy_bound: assert property (busy |-> bcnt_q < 9'(BUSY_CYCLES))
    else $error("busy lasted too long");
  a_busy_sw_hold: assert property (ctl_wr && busy && bcnt_q < 9'h064 |=> busy)
    else $error("software write cleared busy");
  a_busy_read_refused: assert property (x_rd && busy && !x_expanded_ram_sel |=> x_rvalid && x_rerr
    && x_rdata == DEW_BUSY_READ_DATA)
    else $error("load during busy not refused");
  a_load_answer: assert property (x_rvalid == ($past(x_rd) && !$past(x_expanded_ram_sel)))
    else $error("load answer mismatch");
  a_space_route: assert property ((x_wr || x_rd) |->
    x_expanded_ram_sel == (!ctl_rdata[DEW_CTL_SEL_BIT] || x_addr > DEW_EE_LAST))
    else $error("move routed wrongly");
  a_ctl_readback: assert property (ctl_wr |=> ctl_rdata[7:4] == $past(ctl_wdata[7:4])
    && ctl_rdata[1] == $past(ctl_wdata[1]))
    else $error("control readback wrong");
  c_launch: cover property (launch);
  c_busy_read: cover property (x_rd && busy && !x_expanded_ram_sel);
  c_expanded_ram: cover property (x_rd && x_expanded_ram_sel);
endmodule : dew_assertions

//--- dv/tb_top.sv
// Testbench joining both ends, driving the core end over AXI4-Lite
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dew_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [3:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic busy;
  logic sel;
  logic [3:0] page;
  logic [7:0] nbytes;
  logic [7:0] st;
  logic [7:0] res;
  logic [1:0] resp;
  logic [31:0] rv;
  int compares = 0;
  int miscompares = 0;
  always #25 aclk = ~aclk;
  dew_link_if lnk ();
  dew_core_host i_dew_core_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(lnk));
  dew_device i_dew_device (.aclk(aclk), .aresetn(aresetn), .link(lnk), .program_in_progress_flag(busy),
    .nvm_space_select(sel), .latched_page(page), .latched_bytes(nbytes));
  dew_assertions i_dew_assertions (.aclk(aclk), .aresetn(aresetn), .x_addr(lnk.x_addr), .x_wr(lnk.x_wr),
    .x_rd(lnk.x_rd), .x_rdata(lnk.x_rdata), .x_rvalid(lnk.x_rvalid), .x_rerr(lnk.x_rerr),
    .x_expanded_ram_sel(lnk.x_expanded_ram_sel), .ctl_wr(lnk.ctl_wr), .ctl_wdata(lnk.ctl_wdata), .ctl_rdata(lnk.ctl_rdata));

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  // One move or control access, then wait for the command to finish
  task automatic op(input dew_op_t c, input logic [15:0] a, input logic [7:0] d);
    logic [31:0] v;
    wr(DEW_REG_DATA, {24'h0, d});
    wr(DEW_REG_ADDR, {16'h0, a});
    wr(DEW_REG_CMD, {30'h0, c});
    v = 32'h1;
    for (int i = 0; i < 50 && v[DEW_ST_PENDING]; i++) rd(DEW_REG_CMD, v);
    st = v[7:0];
    `CHK("cmd done", 1'b0, v[DEW_ST_PENDING])
    rd(DEW_REG_RESULT, v);
    res = v[7:0];
  endtask : op

  task automatic wait_idle();
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge aclk);
  endtask : wait_idle

  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // About seven and a half times the expected run length, still far inside the cycle budget
  initial
  begin
    #2000000;
    miscompares++;
    summarize();
  end

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    op(DEW_OP_CTL_READ, 16'h0, 8'h0);
    `CHK("ctl reset", 8'h00, res)
    wr(4'h2, 32'h0);
    `CHK("unmapped bresp", DEW_RESP_SLVERR, resp)
    rd(4'h2, rv);
    `CHK("unmapped rresp", DEW_RESP_SLVERR, resp)
    `CHK("unmapped rdata", 32'h0000_0000, rv)
    wr(DEW_REG_DATA, 32'h0000_00c3);
    `CHK("data bresp", DEW_RESP_OKAY, resp)
    rd(DEW_REG_DATA, rv);
    `CHK("data rresp", DEW_RESP_OKAY, resp)
    `CHK("data readback", 32'h0000_00c3, rv)
    op(DEW_OP_CTL_WRITE, 16'h0, 8'h02);
    `CHK("select", 1'b1, sel)
    for (int c = 0; c < 128; c++) op(DEW_OP_STORE, 16'h0280 + 16'(c), 8'(c) ^ 8'h5a);
    `CHK("page", 4'h5, page)
    `CHK("bytes full", 8'h80, nbytes)
    op(DEW_OP_STORE, 16'h0300, 8'h11);
    `CHK("other page err", 1'b1, st[DEW_ST_ERR])
    op(DEW_OP_CTL_WRITE, 16'h0, 8'h52);
    op(DEW_OP_CTL_WRITE, 16'h0, 8'h12);
    op(DEW_OP_CTL_WRITE, 16'h0, 8'ha2);
    `CHK("cancelled key", 1'b0, busy)
    // An Ah nibble closes the host session, so this foreign-page store reaches the latches
    op(DEW_OP_STORE, 16'h0305, 8'h3c);
    `CHK("foreign store taken", 1'b0, st[DEW_ST_ERR])
    `CHK("first page kept", 4'h5, page)
    `CHK("column reused", 8'h80, nbytes)
    op(DEW_OP_CTL_WRITE, 16'h0, 8'h52);
    op(DEW_OP_CTL_WRITE, 16'h0, 8'ha2);
    `CHK("launched", 1'b1, busy)
    op(DEW_OP_LOAD, 16'h0280, 8'h0);
    `CHK("busy load", DEW_BUSY_READ_DATA, res)
    `CHK("busy load err", 1'b1, st[DEW_ST_ERR])
    op(DEW_OP_CTL_WRITE, 16'h0, 8'h02);
    `CHK("busy kept", 1'b1, busy)
    wait_idle();
    `CHK("busy done", 1'b0, busy)
    `CHK("flags cleared", 8'h00, nbytes)
    for (int c = 0; c < 128; c++)
    begin
      op(DEW_OP_LOAD, 16'h0280 + 16'(c), 8'h0);
      `CHK("row byte", (c == 5) ? 8'h3c : 8'(c) ^ 8'h5a, res)
      `CHK("ee route", 1'b0, st[DEW_ST_EXPANDED_RAM])
    end
    op(DEW_OP_STORE, 16'h0281, 8'ha5);
    `CHK("bytes one", 8'h01, nbytes)
    op(DEW_OP_CTL_WRITE, 16'h0, 8'h5e);
    op(DEW_OP_CTL_WRITE, 16'h0, 8'haa);
    `CHK("nibble key", 1'b1, busy)
    wait_idle();
    for (int c = 0; c < 3; c++)
    begin
      op(DEW_OP_LOAD, 16'h0280 + 16'(c), 8'h0);
      `CHK("partial row", (c == 1) ? 8'ha5 : 8'(c) ^ 8'h5a, res)
    end
    op(DEW_OP_LOAD, 16'h0400, 8'h0);
    `CHK("above array", 1'b1, st[DEW_ST_EXPANDED_RAM])
    op(DEW_OP_CTL_WRITE, 16'h0, 8'h00);
    op(DEW_OP_LOAD, 16'h0280, 8'h0);
    `CHK("select clear", 1'b1, st[DEW_ST_EXPANDED_RAM])
    op(DEW_OP_STORE, 16'h0282, 8'h77);
    `CHK("store unselected", 1'b1, st[DEW_ST_ERR])
    `CHK("no latch unselected", 8'h00, nbytes)
    summarize();
  end
endmodule : tb_top
